//--- hdl/sym_pair_buffer.sv
`timescale 1ns/100ps
module sym_pair_buffer (
  input  wire logic                  aclk,      // system clock
  input  wire logic                  aresetn,   // sync reset, active low
  input  wire tx_mod_pkg::sym_item_t in_data,   // item to store
  input  wire logic                  in_valid,  // item offered
  output logic                       in_ready,  // room for an item
  output tx_mod_pkg::sym_item_t      out_data,  // oldest item
  output logic                       out_valid, // item available
  input  wire logic                  out_ready  // consumer takes item
);

  tx_mod_pkg::sym_item_t mem_q [0:1];
  logic [1:0]            count_q;
  logic                  wr_ptr_q;
  logic                  rd_ptr_q;
  logic                  push;
  logic                  pop;
  logic [1:0]            count_d;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign count_d   = count_q + {1'b0, push} - {1'b0, pop};
  assign out_data  = mem_q[rd_ptr_q];
  assign out_valid = (count_q != 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q  <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      count_q  <= count_d;
      in_ready <= (count_d != 2'h2);
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

//--- hdl/tx_mod_pkg.sv
package tx_mod_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYM0_HI    = 8'h4d;
  localparam logic [7:0] IDX_SYM0_LO    = 8'h4e;
  localparam logic [7:0] IDX_SYM1_HI    = 8'h4f;
  localparam logic [7:0] IDX_SYM1_LO    = 8'h50;
  localparam logic [7:0] IDX_SYM2       = 8'h51;
  localparam logic [7:0] IDX_SYM3       = 8'h52;
  localparam logic [7:0] IDX_LEN10      = 8'h53;
  localparam logic [7:0] IDX_LEN32      = 8'h54;
  localparam logic [7:0] IDX_BURST10    = 8'h55;
  localparam logic [7:0] IDX_MOD01      = 8'h56;
  localparam logic [7:0] IDX_MOD23      = 8'h57;
  localparam logic [7:0] IDX_BURST_LEN  = 8'h70;
  localparam logic [7:0] IDX_STATUS     = 8'h71;

  localparam int         NUM_REGS       = 12;
  localparam logic [3:0] SLOT_BURST_LEN = 4'hb;

  // writable bits of each stored register; reserved bits read zero
  localparam logic [7:0] MASK_FULL      = 8'hff;
  localparam logic [7:0] MASK_LEN32     = 8'h77;
  localparam logic [7:0] MASK_BURST10   = 8'h77;
  localparam logic [7:0] MASK_MOD       = 8'h7f;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // modulation register fields
  localparam int MOD_MILLER_BIT  = 6;
  localparam int MOD_PULSE_LSB   = 4;
  localparam int MOD_INVERT_BIT  = 3;
  localparam int MOD_ENV_LSB     = 0;

  // burst control fields (symbol 0 low nibble, symbol 1 high nibble)
  localparam int BURST_EN_BIT    = 0;
  localparam int BURST_ONLY_BIT  = 1;
  localparam int BURST_TYPE_BIT  = 2;
  localparam int SYM1_FIELD_LSB  = 4;

  typedef struct packed {
    logic       miller;
    logic [1:0] pulse;
    logic       invert;
    logic [2:0] env;
  } mod_cfg_t;

  typedef enum logic [1:0] {
    PULSE_NONE    = 2'h0,
    PULSE_START   = 2'h1,
    PULSE_HALF    = 2'h2,
    PULSE_QUARTER = 2'h3
  } pulse_t;

  typedef enum logic [2:0] {
    ENV_DIRECT   = 3'h0,
    ENV_MANCH    = 3'h1,
    ENV_MANCH_SC = 3'h2,
    ENV_BPSK     = 3'h3,
    ENV_RZ_LATE  = 3'h4,
    ENV_RZ_ALT   = 3'h5
  } env_t;

  typedef struct packed {
    logic [1:0] code;
  } sym_item_t;

  // bit timing in clock cycles, four quarters per bit
  localparam logic [3:0] BIT_LAST_PHASE = 4'hf;
  localparam logic [1:0] QUARTER_FIRST  = 2'h0;
  localparam logic [1:0] QUARTER_THIRD  = 2'h2;
  localparam logic [1:0] QUARTER_FOURTH = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hdl/tx_symbol_modulation_encoder.sv
`timescale 1ns/100ps
// Function
// - miller enable on pair 0/1 applies modified miller pulses; only with pulse type 1h (the code applies them with any pulse type)
// - miller enable on pair 2/3 applies modified miller pulses; only with pulse type 1h (the code applies them with any pulse type)
// - pulse type picks none, bit start, third quarter or fourth quarter
// - invert bit of pair 0/1 inverts the output of symbols 0 and 1
// - invert bit of pair 2/3 inverts the output of symbols 2 and 3
// - pair 0/1 envelope: direct, manchester, subcarrier, bpsk, late return-to-zero
// - pair 2/3 envelope same, but code 5h pulses in the first half
// - pattern length is field plus one: 16 bits for 0/1, 8 for 2/3
// - burst-only symbol emits its burst and no pattern bits
module tx_symbol_modulation_encoder (
  input  wire logic                  aclk,      // system clock
  input  wire logic                  aresetn,   // sync reset, active low
  input  wire logic [11:0]           awaddr,    // write address
  input  wire logic [2:0]            awprot,    // unused
  input  wire logic                  awvalid,   // write address valid
  output logic                       awready,   // write address ready
  input  wire logic [31:0]           wdata,     // write data
  input  wire logic [3:0]            wstrb,     // byte enables
  input  wire logic                  wvalid,    // write data valid
  output logic                       wready,    // write data ready
  output logic [1:0]                 bresp,     // write response
  output logic                       bvalid,    // write response valid
  input  wire logic                  bready,    // write response ready
  input  wire logic [11:0]           araddr,    // read address
  input  wire logic [2:0]            arprot,    // unused
  input  wire logic                  arvalid,   // read address valid
  output logic                       arready,   // read address ready
  output logic [31:0]                rdata,     // read data
  output logic [1:0]                 rresp,     // read response
  output logic                       rvalid,    // read data valid
  input  wire logic                  rready,    // read data ready
  input  wire tx_mod_pkg::sym_item_t sym_data,  // symbol to send
  input  wire logic                  sym_valid, // symbol offered
  output logic                       sym_ready, // symbol accepted
  output logic                       mod_out,   // shaped transmit level
  output logic                       mod_active // a symbol is on air
);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_BURST   = 2'b01,
    ST_PATTERN = 2'b10
  } enc_state_t;

  function automatic logic [3:0] slot_of(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (idx == tx_mod_pkg::IDX_BURST_LEN) begin
      slot_of = tx_mod_pkg::SLOT_BURST_LEN;
    end else begin
      slot_of = 4'(idx - tx_mod_pkg::IDX_SYM0_HI);
    end
  endfunction

  function automatic logic mapped(input logic [11:0] addr, input logic with_status);
    logic [7:0] idx;
    idx = addr[9:2];
    mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
             (((idx >= tx_mod_pkg::IDX_SYM0_HI) && (idx <= tx_mod_pkg::IDX_MOD23)) ||
              (idx == tx_mod_pkg::IDX_BURST_LEN) ||
              (with_status && (idx == tx_mod_pkg::IDX_STATUS)));
  endfunction

  function automatic logic [7:0] wmask(input logic [3:0] slot);
    case (slot)
      4'(tx_mod_pkg::IDX_LEN32 - tx_mod_pkg::IDX_SYM0_HI):   wmask = tx_mod_pkg::MASK_LEN32;
      4'(tx_mod_pkg::IDX_BURST10 - tx_mod_pkg::IDX_SYM0_HI): wmask = tx_mod_pkg::MASK_BURST10;
      4'(tx_mod_pkg::IDX_MOD01 - tx_mod_pkg::IDX_SYM0_HI):   wmask = tx_mod_pkg::MASK_MOD;
      4'(tx_mod_pkg::IDX_MOD23 - tx_mod_pkg::IDX_SYM0_HI):   wmask = tx_mod_pkg::MASK_MOD;
      default:                                               wmask = tx_mod_pkg::MASK_FULL;
    endcase
  endfunction

  // shapes one bit at a given phase of its period
  function automatic logic shape(input logic b, input logic prev, input logic pair23,
                                 input tx_mod_pkg::mod_cfg_t cfg, input logic [3:0] phase);
    logic       env;
    logic       second_half;
    logic [1:0] quarter;
    logic       subc;
    logic       window;
    second_half = phase[3];
    quarter     = phase[3:2];
    subc        = phase[1];
    case (cfg.env)
      tx_mod_pkg::ENV_DIRECT:   env = b;
      tx_mod_pkg::ENV_MANCH:    env = b ^ second_half;
      tx_mod_pkg::ENV_MANCH_SC: env = (b ^ second_half) & subc;
      tx_mod_pkg::ENV_BPSK:     env = b ^ subc;
      tx_mod_pkg::ENV_RZ_LATE:  env = b & second_half;
      tx_mod_pkg::ENV_RZ_ALT:   env = pair23 ? (b & ~second_half) : (b & second_half);
      default:                  env = 1'b0;
    endcase
    case (cfg.pulse)
      tx_mod_pkg::PULSE_START:   window = (quarter == tx_mod_pkg::QUARTER_FIRST);
      tx_mod_pkg::PULSE_HALF:    window = (quarter == tx_mod_pkg::QUARTER_THIRD);
      tx_mod_pkg::PULSE_QUARTER: window = (quarter == tx_mod_pkg::QUARTER_FOURTH);
      default:                   window = 1'b1;
    endcase
    if (cfg.miller) begin
      // one pulses mid bit, zero after zero pulses at start, zero after one none
      window = b ? (quarter == tx_mod_pkg::QUARTER_THIRD)
                 : (~prev & (quarter == tx_mod_pkg::QUARTER_FIRST));
      shape  = window;
    end else if (cfg.pulse == tx_mod_pkg::PULSE_NONE) begin
      shape = env;
    end else begin
      shape = env & window;
    end
    if (cfg.env > tx_mod_pkg::ENV_RZ_ALT) begin
      shape = 1'b0;
    end
    shape = shape ^ cfg.invert;
  endfunction

  logic [7:0]            regs_q [0:tx_mod_pkg::NUM_REGS-1];
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [11:0]           waddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  aw_take;
  logic                  w_take;
  logic                  do_write;
  logic                  ar_take;
  logic                  aw_have_d;
  logic                  w_have_d;
  logic                  bvalid_d;
  logic                  rvalid_d;
  logic [3:0]            wslot;
  logic [3:0]            rslot;
  logic [7:0]            rbyte;
  logic                  wr_ok;
  logic                  rd_ok;

  enc_state_t            state_q;
  tx_mod_pkg::sym_item_t buf_data;
  logic                  buf_valid;
  logic                  take_sym;
  logic [1:0]            code_q;
  logic [15:0]           pattern_q;
  logic [3:0]            count_q;
  logic [3:0]            phase_q;
  logic                  prev_bit_q;
  logic                  pair23;
  logic                  cur_bit;
  logic                  bit_end;
  tx_mod_pkg::mod_cfg_t  cfg;

  logic [15:0]           sel_pattern;
  logic [3:0]            sel_len;
  logic [3:0]            sel_burst;
  logic                  sel_burst_en;
  logic                  sel_burst_only;

  // register bus
  assign aw_take   = awvalid & awready;
  assign w_take    = wvalid & wready;
  assign aw_have_d = (aw_have_q | aw_take) & ~do_write;
  assign w_have_d  = (w_have_q | w_take) & ~do_write;
  assign do_write  = aw_have_q & w_have_q & ~bvalid;
  assign bvalid_d  = do_write | (bvalid & ~bready);
  assign ar_take   = arvalid & arready;
  assign rvalid_d  = ar_take | (rvalid & ~rready);
  assign wslot     = slot_of(waddr_q);
  assign rslot     = slot_of(araddr);
  assign wr_ok     = mapped(waddr_q, 1'b0);
  assign rd_ok     = mapped(araddr, 1'b1);
  assign rbyte     = (araddr[9:2] == tx_mod_pkg::IDX_STATUS) ?
                     {5'h00, ~sym_ready, buf_valid, mod_active} : regs_q[rslot];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= tx_mod_pkg::RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= tx_mod_pkg::RESP_OKAY;
      rdata     <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready   <= ~aw_have_d & ~bvalid_d;
      wready    <= ~w_have_d & ~bvalid_d;
      bvalid    <= bvalid_d;
      arready   <= ~rvalid_d;
      rvalid    <= rvalid_d;
      if (do_write) begin
        bresp <= wr_ok ? tx_mod_pkg::RESP_OKAY : tx_mod_pkg::RESP_SLVERR;
      end
      if (ar_take) begin
        rresp <= rd_ok ? tx_mod_pkg::RESP_OKAY : tx_mod_pkg::RESP_SLVERR;
        rdata <= rd_ok ? {24'h000000, rbyte} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      waddr_q <= awaddr;
    end
    if (w_take) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < tx_mod_pkg::NUM_REGS; i++) begin
        regs_q[i] <= tx_mod_pkg::REG_RESET;
      end
    end else if (do_write && wr_ok && wstrb_q[0]) begin
      regs_q[wslot] <= wdata_q[7:0] & wmask(wslot);
    end
  end

  // symbol stream
  sym_pair_buffer u_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (sym_data),
    .in_valid  (sym_valid),
    .in_ready  (sym_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (take_sym)
  );

  assign take_sym = (state_q == ST_IDLE) & buf_valid;

  always_comb begin
    sel_pattern    = 16'h0000;
    sel_len        = 4'h0;
    sel_burst_en   = 1'b0;
    sel_burst_only = 1'b0;
    case (buf_data.code)
      2'h0: begin
        sel_pattern    = {regs_q[0], regs_q[1]};
        sel_len        = regs_q[6][3:0];
        sel_burst_en   = regs_q[8][tx_mod_pkg::BURST_EN_BIT];
        sel_burst_only = regs_q[8][tx_mod_pkg::BURST_ONLY_BIT];
      end
      2'h1: begin
        sel_pattern    = {regs_q[2], regs_q[3]};
        sel_len        = regs_q[6][7:4];
        sel_burst_en   = regs_q[8][tx_mod_pkg::SYM1_FIELD_LSB + tx_mod_pkg::BURST_EN_BIT];
        sel_burst_only = regs_q[8][tx_mod_pkg::SYM1_FIELD_LSB + tx_mod_pkg::BURST_ONLY_BIT];
      end
      2'h2: begin
        sel_pattern = {8'h00, regs_q[4]};
        sel_len     = {1'b0, regs_q[7][2:0]};
      end
      default: begin
        sel_pattern = {8'h00, regs_q[5]};
        sel_len     = {1'b0, regs_q[7][6:4]};
      end
    endcase
  end

  assign sel_burst = buf_data.code[0] ? regs_q[tx_mod_pkg::SLOT_BURST_LEN][7:4]
                                      : regs_q[tx_mod_pkg::SLOT_BURST_LEN][3:0];
  assign pair23    = code_q[1];
  assign cfg       = pair23 ? tx_mod_pkg::mod_cfg_t'(regs_q[10][6:0])
                            : tx_mod_pkg::mod_cfg_t'(regs_q[9][6:0]);
  assign cur_bit   = (state_q == ST_BURST) ?
                     regs_q[8][{code_q[0], 2'h0} + 3'(tx_mod_pkg::BURST_TYPE_BIT)] :
                     pattern_q[count_q];
  assign bit_end   = (phase_q == tx_mod_pkg::BIT_LAST_PHASE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_IDLE;
      code_q     <= 2'h0;
      pattern_q  <= 16'h0000;
      count_q    <= 4'h0;
      phase_q    <= 4'h0;
      prev_bit_q <= 1'b0;
      mod_out    <= 1'b0;
      mod_active <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          phase_q    <= 4'h0;
          mod_out    <= 1'b0;
          mod_active <= 1'b0;
          if (take_sym) begin
            code_q    <= buf_data.code;
            pattern_q <= sel_pattern;
            if (sel_burst_en) begin
              state_q <= ST_BURST;
              count_q <= sel_burst;
            end else if (!sel_burst_only) begin
              state_q <= ST_PATTERN;
              count_q <= sel_len;
            end
          end
        end
        ST_BURST, ST_PATTERN: begin
          mod_active <= 1'b1;
          mod_out    <= shape(cur_bit, prev_bit_q, pair23, cfg, phase_q);
          phase_q    <= phase_q + 4'h1;
          if (bit_end) begin
            prev_bit_q <= cur_bit;
            if (count_q != 4'h0) begin
              count_q <= count_q - 4'h1;
            end else if (state_q == ST_BURST && !regs_q[8][{code_q[0], 2'h0} +
                                                       3'(tx_mod_pkg::BURST_ONLY_BIT)]) begin
              state_q <= ST_PATTERN;
              count_q <= code_q[1] ? {1'b0, code_q[0] ? regs_q[7][6:4] : regs_q[7][2:0]}
                                   : (code_q[0] ? regs_q[6][7:4] : regs_q[6][3:0]);
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- sim/rf_field_listener.sv
`timescale 1ns/100ps
module rf_field_listener (
  input  wire logic    aclk,       // system clock
  input  wire logic    aresetn,    // sync reset, active low
  input  wire logic    mod_out,    // level seen on the field
  input  wire logic    mod_active, // frame on air
  output logic [511:0] wave,       // last frame, cycle 0 first
  output logic [9:0]   wlen,       // cycles in last frame
  output logic [7:0]   frames      // frames seen
);
  logic act_q;
  always @(posedge aclk) begin
    act_q <= mod_active;
    if (!aresetn) begin
      frames <= 8'h00;
    end else if (mod_active && !act_q) begin
      wave <= {511'h0, mod_out};
      wlen <= 10'h001;
    end else if (mod_active) begin
      wave[wlen] <= mod_out;
      wlen <= wlen + 10'h001;
    end else if (act_q) begin
      frames <= frames + 8'h01;
    end
  end
endmodule

//--- sim/tx_symbol_modulation_encoder_asserts.sv
`timescale 1ns/100ps
module tx_symbol_modulation_encoder_asserts (
  input wire logic        aclk,       // clock
  input wire logic        aresetn,    // sync reset
  input wire logic        awvalid,    // aw valid
  input wire logic        awready,    // aw ready
  input wire logic        wvalid,     // w valid
  input wire logic        wready,     // w ready
  input wire logic [1:0]  bresp,      // write response
  input wire logic        bvalid,     // b valid
  input wire logic        bready,     // b ready
  input wire logic        arvalid,    // ar valid
  input wire logic        arready,    // ar ready
  input wire logic [31:0] rdata,      // read data
  input wire logic        rvalid,     // r valid
  input wire logic        rready,     // r ready
  input wire logic        sym_valid,  // symbol offered
  input wire logic        sym_ready,  // symbol room
  input wire logic        mod_out,    // shaped level
  input wire logic        mod_active  // frame on air
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // length of the current frame in cycles
  logic [11:0] run_q;
  always_ff @(posedge aclk) begin
    run_q <= mod_active ? run_q + 12'h001 : 12'h000;
  end

  sequence s_half_bit;
    mod_active [*8];
  endsequence
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  chk_min_frame: assert property ($rose(mod_active) |-> s_half_bit ##1 s_half_bit)
    else $error("frame shorter than one bit");
  chk_whole_bits: assert property ($fell(mod_active) |-> run_q[3:0] == 4'h0)
    else $error("frame not a whole number of bits");
  chk_idle_quiet: assert property (mod_out |-> mod_active)
    else $error("output level outside a frame");
  chk_write_answer: assert property (s_write_taken |-> ##2 bvalid)
    else $error("write response late");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_sym_starts: assert property (sym_valid && sym_ready && !mod_active
                                   |-> ##[1:4] mod_active)
    else $error("frame did not start");
endmodule

bind tx_symbol_modulation_encoder tx_symbol_modulation_encoder_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .sym_valid(sym_valid), .sym_ready(sym_ready),
  .mod_out(mod_out), .mod_active(mod_active)
);

//--- sim/tx_symbol_modulation_encoder_tb.sv
`timescale 1ns/100ps
module tx_symbol_modulation_encoder_tb;
  logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                  sym_valid, awready, wready, bvalid, arready, rvalid;
  logic                  sym_ready, mod_out, mod_active;
  logic [11:0]           awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [1:0]            bresp, rresp;
  logic [511:0]          wave;
  logic [9:0]            wlen;
  logic [7:0]            frames;
  tx_mod_pkg::sym_item_t sym_data;
  int                    err_count, checks_done;

  tx_symbol_modulation_encoder DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sym_data(sym_data), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .mod_out(mod_out), .mod_active(mod_active)
  );
  rf_field_listener card (
    .aclk(aclk), .aresetn(aresetn), .mod_out(mod_out), .mod_active(mod_active),
    .wave(wave), .wlen(wlen), .frames(frames)
  );

  always #5 aclk = ~aclk;

  task automatic chk(input string n, input logic [511:0] s, input logic [511:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
  endtask

  // expected level of one cycle of a bit
  function automatic logic ev(input logic b, pb, input logic [6:0] c,
                              input logic p23, input logic [3:0] ph);
    logic h, e, w;
    h = !ph[3];
    case (c[2:0])
      3'h0: e = b;
      3'h1: e = h ? b : !b;
      3'h2: e = (h ? b : !b) & ph[1];
      3'h3: e = b ^ ph[1];
      3'h4: e = b & !h;
      3'h5: e = b & (p23 ? h : !h);
      default: e = 1'b0;
    endcase
    case (c[5:4])
      2'h0: w = 1'b1;
      2'h1: w = ph[3:2] == 2'h0;
      2'h2: w = ph[3:2] == 2'h2;
      default: w = ph[3:2] == 2'h3;
    endcase
    if (c[6]) e = b ? ph[3:2] == 2'h2 : !pb && ph[3:2] == 2'h0;
    else e = e & w;
    return e ^ c[3];
  endfunction

  task automatic run_sym(input logic [1:0] c, input logic [6:0] cf, input logic p23,
                         input logic [15:0] bits, input int nb, input string n);
    logic [511:0] ex;
    logic [7:0]   f0;
    logic         b, pb;
    ex = '0;
    pb = 1'b0;
    for (int i = 0; i < nb; i++) begin
      b = bits[nb-1-i];
      for (int p = 0; p < 16; p++) ex[i*16+p] = ev(b, pb, cf, p23, 4'(p));
      pb = b;
    end
    f0 = frames;
    @(posedge aclk);
    sym_data <= '{code: c};
    sym_valid <= 1'b1;
    do @(posedge aclk); while (!sym_ready);
    sym_valid <= 1'b0;
    while (frames == f0) @(posedge aclk);
    chk({n, " len"}, 512'(wlen), 512'(nb * 16));
    chk(n, wave, ex);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(tx_mod_pkg::IDX_MOD01, d, r);
    chk("mod01 reset", 512'(d), 512'(0));
    wr(tx_mod_pkg::IDX_MOD01, 8'hff, r);
    chk("mod01 bresp", 512'(r), 512'(tx_mod_pkg::RESP_OKAY));
    rd(tx_mod_pkg::IDX_MOD01, d, r);
    chk("mod01 bit7", 512'(d), 512'(32'h7f));
    chk("mod01 rresp", 512'(r), 512'(tx_mod_pkg::RESP_OKAY));
    cfg(tx_mod_pkg::IDX_MOD23, 8'hff);
    rd(tx_mod_pkg::IDX_MOD23, d, r);
    chk("mod23 bit7", 512'(d), 512'(32'h7f));
    rd(8'h60, d, r);
    chk("unmapped rresp", 512'(r), 512'(tx_mod_pkg::RESP_SLVERR));
    chk("unmapped rdata", 512'(d), 512'(0));
    wr(8'h60, 8'h01, r);
    chk("unmapped bresp", 512'(r), 512'(tx_mod_pkg::RESP_SLVERR));
  endtask

  task automatic t_env;
    logic [6:0] cf;
    for (int p = 0; p < 2; p++)
      for (int e = 0; e < 8; e++)
        for (int v = 0; v < 2; v++) begin
          cf = {3'h0, v[0], e[2:0]};
          cfg(p[0] ? tx_mod_pkg::IDX_MOD23 : tx_mod_pkg::IDX_MOD01, {1'b0, cf});
          run_sym({p[0], v[0]}, cf, p[0], 16'h0002, 2, "envelope");
        end
  endtask

  task automatic t_pulse;
    logic [6:0] cf;
    for (int t = 0; t < 4; t++) begin
      cf = {1'b0, t[1:0], 4'h0};
      cfg(tx_mod_pkg::IDX_MOD01, {1'b0, cf});
      run_sym(2'h0, cf, 1'b0, 16'h0002, 2, "pulse");
    end
  endtask

  task automatic t_miller;
    cfg(tx_mod_pkg::IDX_LEN10, 8'h12);
    cfg(tx_mod_pkg::IDX_SYM0_LO, 8'h04);
    cfg(tx_mod_pkg::IDX_MOD01, 8'h50);
    run_sym(2'h0, 7'h50, 1'b0, 16'h0004, 3, "miller01");
    cfg(tx_mod_pkg::IDX_LEN32, 8'h12);
    cfg(tx_mod_pkg::IDX_SYM2, 8'h04);
    cfg(tx_mod_pkg::IDX_MOD23, 8'h50);
    run_sym(2'h2, 7'h50, 1'b1, 16'h0004, 3, "miller23");
  endtask

  task automatic t_len_burst;
    cfg(tx_mod_pkg::IDX_MOD01, 8'h00);
    cfg(tx_mod_pkg::IDX_MOD23, 8'h00);
    cfg(tx_mod_pkg::IDX_LEN10, 8'h1f);
    cfg(tx_mod_pkg::IDX_SYM0_HI, 8'ha5);
    cfg(tx_mod_pkg::IDX_SYM0_LO, 8'hc3);
    run_sym(2'h0, 7'h00, 1'b0, 16'ha5c3, 16, "len16");
    cfg(tx_mod_pkg::IDX_LEN32, 8'h70);
    cfg(tx_mod_pkg::IDX_SYM3, 8'h96);
    run_sym(2'h3, 7'h00, 1'b1, 16'h0096, 8, "len8");
    cfg(tx_mod_pkg::IDX_BURST_LEN, 8'h02);
    cfg(tx_mod_pkg::IDX_BURST10, 8'h07);
    run_sym(2'h0, 7'h00, 1'b0, 16'h0007, 3, "burst only");
    cfg(tx_mod_pkg::IDX_BURST10, 8'h70);
    run_sym(2'h1, 7'h00, 1'b0, 16'h0001, 1, "burst only 1");
    cfg(tx_mod_pkg::IDX_LEN10, 8'h11);
    cfg(tx_mod_pkg::IDX_SYM0_LO, 8'h02);
    cfg(tx_mod_pkg::IDX_BURST10, 8'h05);
    run_sym(2'h0, 7'h00, 1'b0, 16'h001e, 5, "burst and pattern");
    cfg(tx_mod_pkg::IDX_BURST10, 8'h00);
  endtask

  // fill the buffer until it refuses, then let it drain
  task automatic t_buffer;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  f0, k;
    cfg(tx_mod_pkg::IDX_LEN10, 8'h1f);
    f0 = frames;
    k = 8'h00;
    @(posedge aclk);
    sym_data <= '{code: 2'h0};
    sym_valid <= 1'b1;
    do begin
      @(posedge aclk);
      if (sym_ready) k++;
    end while (sym_ready && k < 8'h08);
    sym_valid <= 1'b0;
    rd(tx_mod_pkg::IDX_STATUS, d, r);
    chk("status busy full", 512'(d[2:0]), 512'(3'h7));
    chk("taken before full", 512'(k > 8'h02), 512'(1'b1));
    while (frames != f0 + k) @(posedge aclk);
    rd(tx_mod_pkg::IDX_STATUS, d, r);
    chk("status drained", 512'(d[2:0]), 512'(3'h0));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sym_valid} = '0;
    {awaddr, araddr, wdata} = '0;
    sym_data = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    cfg(tx_mod_pkg::IDX_SYM0_LO, 8'h02);
    cfg(tx_mod_pkg::IDX_SYM1_LO, 8'h02);
    cfg(tx_mod_pkg::IDX_SYM2, 8'h02);
    cfg(tx_mod_pkg::IDX_SYM3, 8'h02);
    cfg(tx_mod_pkg::IDX_LEN10, 8'h11);
    cfg(tx_mod_pkg::IDX_LEN32, 8'h11);
    t_env;
    t_pulse;
    t_miller;
    t_len_burst;
    t_buffer;
    tally_and_finish;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end
endmodule
